// file: verilog/pwsc_pkg.sv
// Constants, types and helper functions of the PWM phase, sync and input threshold command bank
// Notes on behaviour
// - Phase offset equals phase selector code times fifteen degrees, codes 0x00 to 0x17.
// - With global bit 6 clear, populated resistors replace stored phase selector at power-up.
// - Sync config bit 1 clear means an applied external sync clock is used; resets clear.
// - Sync config bit 1 set means the external sync clock is ignored in normal operation.
// - While sync output is enabled by bit 0, the sync input is always ignored.
// - During reset an external sync clock may be honoured even with ignore set.
// - External clock at power-on with resistors enabled sets internal settings from that condition.
// - Sync bit 0 enables sync output, only after input first exceeds start threshold.
// - With global bit 6 clear, resistors may replace stored sync config at power-up.
// - Command 0x35 start threshold word, default 1.4 V, conversion starts above it.
// - Command 0x36 stop threshold word, default 1.35 V, conversion stops at or below.
// - Command 0x58 undervoltage warning limit word, default -1.0 V.
// - Start threshold is two bytes of half float, accepted only from 1.4 to 16.0 V.
// - Conversion never starts unless auxiliary supply or input exceeds 2.9 V.
// - Undervoltage warning stays masked until input once exceeds the warning limit.
// - Warning sets summary, input and input-status bits and pulls alert low unless masked.
package pwsc_pkg;

	// Command codes
	localparam logic [7:0] CMD_CLEAR       = 8'h03;
	localparam logic [7:0] CMD_START       = 8'h35;
	localparam logic [7:0] CMD_STOP        = 8'h36;
	localparam logic [7:0] CMD_UV_WARN     = 8'h58;
	localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
	localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
	localparam logic [7:0] CMD_STATUS_IN   = 8'h7c;
	localparam logic [7:0] CMD_PHASE       = 8'hf5;
	localparam logic [7:0] CMD_SYNC        = 8'hf6;

	// Half float values
	localparam logic [15:0] START_RST   = 16'h3d9a;
	localparam logic [15:0] STOP_RST    = 16'h3d66;
	localparam logic [15:0] UV_WARN_RST = 16'hbc00;
	localparam logic [15:0] START_MIN   = 16'h3d9a;
	localparam logic [15:0] STOP_MIN    = 16'h3d66;
	localparam logic [15:0] UV_WARN_MIN = 16'hbc00;
	localparam logic [15:0] THRESH_MAX  = 16'h4c00;
	localparam logic [15:0] UV_WARN_MAX = 16'h4d80;
	localparam logic [15:0] SUPPLY_MIN  = 16'h41cd;
	localparam logic [15:0] FP16_SIGN   = 16'h8000;

	// Field layout
	localparam int         SYNC_OUT_EN_BIT  = 0;
	localparam int         SYNC_IGNORE_BIT  = 1;
	localparam int         GLOBAL_NO_RES    = 6;
	localparam logic [7:0] SYNC_RST         = 8'h00;
	localparam logic [7:0] SYNC_WR_MASK     = 8'h03;
	localparam logic [7:0] PHASE_RST        = 8'h00;
	localparam logic [7:0] PHASE_MAX        = 8'h17;
	localparam logic [11:0] PHASE_STEP_DEG  = 12'h00f;
	localparam int         STAT_NOTA_BIT    = 0;
	localparam int         STAT_INPUT_BIT   = 13;
	localparam int         STAT_IN_UVW_BIT  = 5;
	localparam logic [6:0] DEV_ADDR_RST     = 7'h40;
	localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

	// Timing
	localparam int CORE_CLK_PERIOD_NS = 100;
	localparam int EXT_TIMEOUT_NS     = 1600;
	localparam int BOOT_NS            = 4000;
	localparam int SYNC_HALF_NS       = 500;
	localparam int EXT_TIMEOUT_CYC    = EXT_TIMEOUT_NS / CORE_CLK_PERIOD_NS;
	localparam int BOOT_CYC           = BOOT_NS / CORE_CLK_PERIOD_NS;
	localparam int SYNC_HALF_CYC      = SYNC_HALF_NS / CORE_CLK_PERIOD_NS;

	typedef enum logic [3:0] {
		ST_IDLE      = 4'h0,
		ST_ADDR      = 4'h1,
		ST_ADDR_ACK  = 4'h2,
		ST_CMD       = 4'h3,
		ST_CMD_ACK   = 4'h4,
		ST_WDATA     = 4'h5,
		ST_WDATA_ACK = 4'h6,
		ST_RDATA     = 4'h7,
		ST_RDATA_ACK = 4'h8
	} pwsc_bus_state_t;

	// Order preserving key of a half float
	function automatic logic [15:0] fp16_key(input logic [15:0] x);
		fp16_key = x[15] ? ~x : (x | FP16_SIGN);
	endfunction

	function automatic logic fp16_gt(input logic [15:0] a, input logic [15:0] b);
		fp16_gt = fp16_key(a) > fp16_key(b);
	endfunction

	function automatic logic fp16_in(input logic [15:0] x, input logic [15:0] lo, input logic [15:0] hi);
		fp16_in = !fp16_gt(lo, x) && !fp16_gt(x, hi);
	endfunction

	// Data bytes a write of each command carries
	function automatic logic [1:0] cmd_wlen(input logic [7:0] c);
		case (c)
			CMD_START, CMD_STOP, CMD_UV_WARN: cmd_wlen = 2'h2;
			CMD_PHASE, CMD_SYNC:              cmd_wlen = 2'h1;
			default:                          cmd_wlen = 2'h0;
		endcase
	endfunction

	function automatic logic cmd_known(input logic [7:0] c);
		case (c)
			CMD_CLEAR, CMD_START, CMD_STOP, CMD_UV_WARN, CMD_STATUS_BYTE,
			CMD_STATUS_WORD, CMD_STATUS_IN, CMD_PHASE, CMD_SYNC: cmd_known = 1'b1;
			default:                                             cmd_known = 1'b0;
		endcase
	endfunction

endpackage

// file: verilog/pwsc_sync3.sv
// Three stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pwsc_sync3 (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Pin and filtered level
	input  wire logic d,
	output logic      q
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			q    <= 1'b0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				q <= s3_q;
			end
		end
	end
endmodule

// file: verilog/pwsc_top.sv
// Phase, sync clock and input threshold command bank behind a two-wire command port
`timescale 1ns/1ps
module pwsc_top #(
	parameter logic [6:0] DEV_ADDR = pwsc_pkg::DEV_ADDR_RST
) (
	// Core clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Two-wire command port
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	output logic             alert_out,
	output logic             alert_oe,
	// Sync pin
	input  wire logic        sync_clk,
	output logic             sync_out,
	output logic             sync_oe,
	// Input voltage telemetry and supply sense
	input  wire logic [15:0] vin_code,
	input  wire logic        vin_valid,
	input  wire logic        aux_supply_ok,
	// Stored values and configuration resistors
	input  wire logic [7:0]  global_configuration,
	input  wire logic [7:0]  nvm_phase,
	input  wire logic [7:0]  nvm_sync,
	input  wire logic [15:0] nvm_start,
	input  wire logic [15:0] nvm_stop,
	input  wire logic [15:0] nvm_uv_warn,
	input  wire logic        res_present,
	input  wire logic [7:0]  res_phase,
	input  wire logic [7:0]  res_sync,
	input  wire logic        uv_alert_mask,
	// Regulator controls
	output logic [8:0]       phase_offset_deg,
	output logic             ext_sync_used,
	output logic             ext_sync_strap,
	output logic             conversion_on,
	output logic             uv_warning
);
	localparam logic [5:0] EXT_TIMEOUT = 6'(pwsc_pkg::EXT_TIMEOUT_CYC);
	localparam logic [5:0] BOOT_LEN    = 6'(pwsc_pkg::BOOT_CYC);
	localparam logic [3:0] SYNC_HALF   = 4'(pwsc_pkg::SYNC_HALF_CYC - 1);

	function automatic logic [8:0] phase_to_deg(input logic [7:0] code);
		logic [11:0] p;
		p = {4'h0, code} * pwsc_pkg::PHASE_STEP_DEG;
		phase_to_deg = (code > pwsc_pkg::PHASE_MAX) ? 9'h000 : p[8:0];
	endfunction

	// Synchronised pins
	logic scl_s;
	logic sda_s;
	logic aux_s;
	logic ext_tog_s;
	logic [2:0] link_cnt_q;
	logic link_rst1_q;
	logic link_rst2_q;

	pwsc_sync3 u_sync_scl (.clk(core_clk), .rst(rst), .d(scl_in), .q(scl_s));
	pwsc_sync3 u_sync_sda (.clk(core_clk), .rst(rst), .d(sda_in), .q(sda_s));
	pwsc_sync3 u_sync_aux (.clk(core_clk), .rst(rst), .d(aux_supply_ok), .q(aux_s));
	pwsc_sync3 u_sync_ext (.clk(core_clk), .rst(rst), .d(link_cnt_q[2]), .q(ext_tog_s));

	// Link domain: divided activity marker of the external clock
	always_ff @(posedge sync_clk) begin
		link_rst1_q <= rst;
		link_rst2_q <= link_rst1_q;
		if (link_rst2_q) begin
			link_cnt_q <= 3'h0;
		end else begin
			link_cnt_q <= link_cnt_q + 3'h1;
		end
	end

	// External clock presence
	logic       ext_tog_p_q;
	logic [5:0] ext_timer_q;
	logic       ext_present_q;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ext_tog_p_q   <= 1'b0;
			ext_timer_q   <= EXT_TIMEOUT;
			ext_present_q <= 1'b0;
		end else begin
			ext_tog_p_q <= ext_tog_s;
			if (ext_tog_s != ext_tog_p_q) begin
				ext_timer_q <= 6'h00;
			end else if (ext_timer_q != EXT_TIMEOUT) begin
				ext_timer_q <= ext_timer_q + 6'h01;
			end
			ext_present_q <= ext_timer_q != EXT_TIMEOUT;
		end
	end

	// Bus conditions
	logic scl_p_q;
	logic sda_p_q;
	logic bus_start;
	logic bus_stop;
	logic scl_rise;
	logic scl_fall;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	assign bus_start = scl_p_q && scl_s && sda_p_q && !sda_s;
	assign bus_stop  = scl_p_q && scl_s && !sda_p_q && sda_s;
	assign scl_rise  = !scl_p_q && scl_s;
	assign scl_fall  = scl_p_q && !scl_s;

	// Register state
	logic [7:0]  cmd_q;
	logic [7:0]  phase_q;
	logic [7:0]  sync_cfg_q;
	logic [15:0] start_q;
	logic [15:0] stop_q;
	logic [15:0] uv_warn_q;
	logic        uv_q;
	logic [15:0] rd_val;

	always_comb begin
		rd_val = 16'h0000;
		case (cmd_q)
			pwsc_pkg::CMD_START:       rd_val = start_q;
			pwsc_pkg::CMD_STOP:        rd_val = stop_q;
			pwsc_pkg::CMD_UV_WARN:     rd_val = uv_warn_q;
			pwsc_pkg::CMD_PHASE:       rd_val = {8'h00, phase_q};
			pwsc_pkg::CMD_SYNC:        rd_val = {8'h00, sync_cfg_q};
			pwsc_pkg::CMD_STATUS_BYTE: rd_val[pwsc_pkg::STAT_NOTA_BIT] = uv_q;
			pwsc_pkg::CMD_STATUS_WORD: begin
				rd_val[pwsc_pkg::STAT_NOTA_BIT]  = uv_q;
				rd_val[pwsc_pkg::STAT_INPUT_BIT] = uv_q;
			end
			pwsc_pkg::CMD_STATUS_IN:   rd_val[pwsc_pkg::STAT_IN_UVW_BIT] = uv_q;
			default:                   rd_val = 16'h0000;
		endcase
	end

	// Command port state machine
	pwsc_pkg::pwsc_bus_state_t state_q;
	logic [3:0]  bit_cnt_q;
	logic [7:0]  shift_q;
	logic [15:0] wbuf_q;
	logic [1:0]  wcnt_q;
	logic [15:0] rbuf_q;
	logic        rd_q;
	logic        cmd_seen_q;
	logic        sda_oe_q;
	logic        commit_q;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q    <= pwsc_pkg::ST_IDLE;
			bit_cnt_q  <= 4'h0;
			shift_q    <= 8'h00;
			cmd_q      <= 8'h00;
			wbuf_q     <= 16'h0000;
			wcnt_q     <= 2'h0;
			rbuf_q     <= 16'h0000;
			rd_q       <= 1'b0;
			cmd_seen_q <= 1'b0;
			sda_oe_q   <= 1'b0;
			commit_q   <= 1'b0;
		end else begin
			commit_q <= 1'b0;
			if (bus_start) begin
				state_q   <= pwsc_pkg::ST_ADDR;
				bit_cnt_q <= 4'h0;
				wcnt_q    <= 2'h0;
				sda_oe_q  <= 1'b0;
			end else if (bus_stop) begin
				state_q    <= pwsc_pkg::ST_IDLE;
				sda_oe_q   <= 1'b0;
				commit_q   <= cmd_seen_q && (wcnt_q == pwsc_pkg::cmd_wlen(cmd_q));
				cmd_seen_q <= 1'b0;
			end else begin
				unique case (state_q)
					pwsc_pkg::ST_IDLE: begin
						sda_oe_q <= 1'b0;
					end
					pwsc_pkg::ST_ADDR, pwsc_pkg::ST_CMD, pwsc_pkg::ST_WDATA: begin
						if (scl_rise && bit_cnt_q != pwsc_pkg::BITS_PER_BYTE) begin
							shift_q   <= {shift_q[6:0], sda_s};
							bit_cnt_q <= bit_cnt_q + 4'h1;
						end else if (scl_fall && bit_cnt_q == pwsc_pkg::BITS_PER_BYTE) begin
							bit_cnt_q <= 4'h0;
							state_q   <= pwsc_pkg::ST_IDLE;
							if (state_q == pwsc_pkg::ST_ADDR) begin
								if (shift_q[7:1] == DEV_ADDR) begin
									rd_q     <= shift_q[0];
									sda_oe_q <= 1'b1;
									state_q  <= pwsc_pkg::ST_ADDR_ACK;
								end
							end else if (state_q == pwsc_pkg::ST_CMD) begin
								if (pwsc_pkg::cmd_known(shift_q)) begin
									cmd_q      <= shift_q;
									cmd_seen_q <= 1'b1;
									sda_oe_q   <= 1'b1;
									state_q    <= pwsc_pkg::ST_CMD_ACK;
								end
							end else if (wcnt_q < pwsc_pkg::cmd_wlen(cmd_q)) begin
								if (wcnt_q == 2'h0) begin
									wbuf_q[7:0] <= shift_q;
								end else begin
									wbuf_q[15:8] <= shift_q;
								end
								wcnt_q   <= wcnt_q + 2'h1;
								sda_oe_q <= 1'b1;
								state_q  <= pwsc_pkg::ST_WDATA_ACK;
							end
						end
					end
					pwsc_pkg::ST_ADDR_ACK, pwsc_pkg::ST_CMD_ACK, pwsc_pkg::ST_WDATA_ACK: begin
						if (scl_fall) begin
							if (state_q == pwsc_pkg::ST_ADDR_ACK && rd_q) begin
								shift_q    <= rd_val[7:0];
								rbuf_q     <= {8'h00, rd_val[15:8]};
								sda_oe_q   <= !rd_val[7];
								cmd_seen_q <= 1'b0;
								state_q    <= pwsc_pkg::ST_RDATA;
							end else begin
								sda_oe_q <= 1'b0;
								state_q  <= (state_q == pwsc_pkg::ST_ADDR_ACK) ? pwsc_pkg::ST_CMD : pwsc_pkg::ST_WDATA;
							end
						end
					end
					pwsc_pkg::ST_RDATA: begin
						if (scl_fall) begin
							if (bit_cnt_q == pwsc_pkg::BITS_PER_BYTE - 4'h1) begin
								bit_cnt_q <= 4'h0;
								sda_oe_q  <= 1'b0;
								state_q   <= pwsc_pkg::ST_RDATA_ACK;
							end else begin
								bit_cnt_q <= bit_cnt_q + 4'h1;
								shift_q   <= {shift_q[6:0], 1'b0};
								sda_oe_q  <= !shift_q[6];
							end
						end
					end
					pwsc_pkg::ST_RDATA_ACK: begin
						if (scl_rise && sda_s) begin
							state_q <= pwsc_pkg::ST_IDLE;
						end else if (scl_fall) begin
							shift_q  <= rbuf_q[7:0];
							rbuf_q   <= {8'h00, rbuf_q[15:8]};
							sda_oe_q <= !rbuf_q[7];
							state_q  <= pwsc_pkg::ST_RDATA;
						end
					end
					default: begin
						state_q  <= pwsc_pkg::ST_IDLE;
						sda_oe_q <= 1'b0;
					end
				endcase
			end
		end
	end

	// Power-up load window
	logic [5:0] boot_cnt_q;
	logic       booted_q;
	logic       res_use;
	logic       clear_req;

	assign res_use   = res_present && !global_configuration[pwsc_pkg::GLOBAL_NO_RES];
	assign clear_req = commit_q && cmd_q == pwsc_pkg::CMD_CLEAR;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			boot_cnt_q <= 6'h00;
			booted_q   <= 1'b0;
		end else if (!booted_q) begin
			boot_cnt_q <= boot_cnt_q + 6'h01;
			booted_q   <= boot_cnt_q == BOOT_LEN;
		end
	end

	// Register bank load and write
	always_ff @(posedge core_clk) begin
		if (rst) begin
			phase_q    <= pwsc_pkg::PHASE_RST;
			sync_cfg_q <= pwsc_pkg::SYNC_RST;
			start_q    <= pwsc_pkg::START_RST;
			stop_q     <= pwsc_pkg::STOP_RST;
			uv_warn_q  <= pwsc_pkg::UV_WARN_RST;
		end else if (!booted_q) begin
			if (boot_cnt_q == BOOT_LEN) begin
				phase_q    <= res_use ? res_phase : nvm_phase;
				sync_cfg_q <= (res_use ? res_sync : nvm_sync) & pwsc_pkg::SYNC_WR_MASK;
				start_q    <= nvm_start;
				stop_q     <= nvm_stop;
				uv_warn_q  <= nvm_uv_warn;
			end
		end else if (commit_q) begin
			case (cmd_q)
				pwsc_pkg::CMD_START: begin
					if (pwsc_pkg::fp16_in(wbuf_q, pwsc_pkg::START_MIN, pwsc_pkg::THRESH_MAX)) begin
						start_q <= wbuf_q;
					end
				end
				pwsc_pkg::CMD_STOP: begin
					if (pwsc_pkg::fp16_in(wbuf_q, pwsc_pkg::STOP_MIN, pwsc_pkg::THRESH_MAX)) begin
						stop_q <= wbuf_q;
					end
				end
				pwsc_pkg::CMD_UV_WARN: begin
					if (pwsc_pkg::fp16_in(wbuf_q, pwsc_pkg::UV_WARN_MIN, pwsc_pkg::UV_WARN_MAX)) begin
						uv_warn_q <= wbuf_q;
					end
				end
				pwsc_pkg::CMD_PHASE: phase_q <= wbuf_q[7:0];
				pwsc_pkg::CMD_SYNC:  sync_cfg_q <= wbuf_q[7:0] & pwsc_pkg::SYNC_WR_MASK;
				default:             phase_q <= phase_q;
			endcase
		end
	end

	// Conversion control and first start
	logic run_q;
	logic started_once_q;
	logic supply_ok;

	assign supply_ok = aux_s || pwsc_pkg::fp16_gt(vin_code, pwsc_pkg::SUPPLY_MIN);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			run_q          <= 1'b0;
			started_once_q <= 1'b0;
		end else if (vin_valid && booted_q) begin
			if (!run_q && supply_ok && pwsc_pkg::fp16_gt(vin_code, start_q)) begin
				run_q          <= 1'b1;
				started_once_q <= 1'b1;
			end else if (run_q && !pwsc_pkg::fp16_gt(vin_code, stop_q)) begin
				run_q <= 1'b0;
			end
		end
	end

	// Input undervoltage warning
	logic uv_armed_q;
	logic uv_event;

	assign uv_event = uv_armed_q && vin_valid && pwsc_pkg::fp16_gt(uv_warn_q, vin_code);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			uv_armed_q <= 1'b0;
			uv_q       <= 1'b0;
		end else begin
			if (vin_valid && pwsc_pkg::fp16_gt(vin_code, uv_warn_q)) begin
				uv_armed_q <= 1'b1;
			end
			if (uv_event) begin
				uv_q <= 1'b1;
			end else if (clear_req) begin
				uv_q <= 1'b0;
			end
		end
	end

	// Sync selection, strap and output clock
	logic [3:0] sync_div_q;
	logic       sync_run;

	assign sync_run = booted_q && started_once_q && sync_cfg_q[pwsc_pkg::SYNC_OUT_EN_BIT];

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ext_sync_used  <= 1'b0;
			ext_sync_strap <= 1'b0;
		end else begin
			ext_sync_used <= ext_present_q && (!booted_q ||
				(!sync_cfg_q[pwsc_pkg::SYNC_IGNORE_BIT] &&
				!sync_cfg_q[pwsc_pkg::SYNC_OUT_EN_BIT]));
			if (!booted_q && boot_cnt_q == BOOT_LEN) begin
				ext_sync_strap <= ext_present_q && !global_configuration[pwsc_pkg::GLOBAL_NO_RES];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst || !sync_run) begin
			sync_div_q <= 4'h0;
			sync_out   <= 1'b0;
			sync_oe    <= 1'b0;
		end else begin
			sync_oe <= 1'b1;
			if (sync_div_q == SYNC_HALF) begin
				sync_div_q <= 4'h0;
				sync_out   <= !sync_out;
			end else begin
				sync_div_q <= sync_div_q + 4'h1;
			end
		end
	end

	// Output flops
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sda_out          <= 1'b0;
			sda_oe           <= 1'b0;
			alert_out        <= 1'b0;
			alert_oe         <= 1'b0;
			phase_offset_deg <= 9'h000;
			conversion_on    <= 1'b0;
			uv_warning       <= 1'b0;
		end else begin
			sda_out          <= 1'b0;
			sda_oe           <= sda_oe_q;
			alert_out        <= 1'b0;
			alert_oe         <= uv_q && !uv_alert_mask;
			phase_offset_deg <= phase_to_deg(phase_q);
			conversion_on    <= run_q;
			uv_warning       <= uv_q;
		end
	end
endmodule

// file: testbench/pwsc_chk_sva.sv
// Concurrent checks on the command bank ports
`timescale 1ns/1ps
module pwsc_chk (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        rst,
	// Watched ports
	input wire logic        alert_out,
	input wire logic        alert_oe,
	input wire logic        sync_oe,
	input wire logic        sync_out,
	input wire logic [15:0] vin_code,
	input wire logic        vin_valid,
	input wire logic        aux_supply_ok,
	input wire logic [7:0]  global_configuration,
	input wire logic        uv_alert_mask,
	input wire logic [8:0]  phase_offset_deg,
	input wire logic        ext_sync_used,
	input wire logic        ext_sync_strap,
	input wire logic        conversion_on,
	input wire logic        uv_warning
);
	logic [5:0] up_q;

	// Cycles since reset release, saturating
	always_ff @(posedge core_clk) begin
		if (rst) begin
			up_q <= 6'h00;
		end else if (up_q != 6'h3f) begin
			up_q <= up_q + 6'h01;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	phase_grid_a: assert property (phase_offset_deg <= 9'd345 && phase_offset_deg % 15 == 0)
		else $error("phase offset off grid");
	strap_hold_a: assert property (up_q == 6'h3f && $past(up_q) == 6'h3f |-> $stable(ext_sync_strap))
		else $error("strap changed after boot");
	strap_res_a: assert property (ext_sync_strap |-> !global_configuration[6])
		else $error("strap with resistors disabled");
	sync_ignore_a: assert property (sync_oe [*3] |-> !ext_sync_used)
		else $error("sync input used while output on");
	sync_toggle_a: assert property (sync_oe && $past(sync_oe) |-> ##[0:5] ($changed(sync_out) || !sync_oe))
		else $error("sync output not toggling");
	conv_supply_a: assert property ($rose(conversion_on) |->
		aux_supply_ok || (!vin_code[15] && vin_code > 16'h41cd))
		else $error("conversion started without supply");
	conv_sample_a: assert property ($changed(conversion_on) |-> $past(vin_valid) || $past(vin_valid, 2))
		else $error("conversion changed without sample");
	uv_alert_a: assert property ($rose(uv_warning) && !uv_alert_mask |-> ##1 alert_oe)
		else $error("alert missing on warning");
	alert_cause_a: assert property (alert_oe |-> uv_warning || $past(uv_warning))
		else $error("alert without warning");
	alert_low_a: assert property (alert_oe |-> !alert_out)
		else $error("alert not driven low");
	alert_mask_a: assert property (uv_alert_mask [*3] |-> !alert_oe)
		else $error("alert while masked");

	cover property ($rose(conversion_on));
	cover property ($rose(alert_oe));
	cover property ($rose(sync_oe));
endmodule

bind pwsc_top pwsc_chk i_pwsc_chk (.core_clk(core_clk), .rst(rst), .alert_out(alert_out), .alert_oe(alert_oe),
	.sync_oe(sync_oe), .vin_code(vin_code), .vin_valid(vin_valid), .aux_supply_ok(aux_supply_ok),
	.global_configuration(global_configuration), .uv_alert_mask(uv_alert_mask), .phase_offset_deg(phase_offset_deg),
	.ext_sync_used(ext_sync_used), .ext_sync_strap(ext_sync_strap), .conversion_on(conversion_on),
	.uv_warning(uv_warning), .sync_out(sync_out));

// file: testbench/pwsc_host_model.sv
// Two-wire host controller model driving the command port
`timescale 1ns/1ps
module pwsc_host_model #(
	parameter logic [6:0] DEV_ADDR = pwsc_pkg::DEV_ADDR_RST
) (
	// Clock
	input  wire logic        core_clk,
	// Bus pins
	input  wire logic        sda_oe,
	output logic             scl,
	output logic             sda,
	// Read result
	output logic             rd_done,
	output logic [15:0]      rd_data
);
	logic sda_h;

	initial begin
		scl = 1'b1;
		sda_h = 1'b1;
		rd_done = 1'b0;
		rd_data = 16'h0000;
	end

	// Pull-up wins unless a party pulls low
	assign sda = sda_h && !sda_oe;

	task automatic q();
		repeat (12) @(posedge core_clk);
	endtask

	task automatic bit_io(input logic b, output logic r);
		sda_h <= b;
		q();
		scl <= 1'b1;
		q();
		q();
		r = sda;
		scl <= 1'b0;
		q();
	endtask

	task automatic xb(input logic [7:0] w, input logic last, output logic [7:0] r);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_io(w[i], r[i]);
		end
		bit_io(last, a);
	endtask

	task automatic start();
		sda_h <= 1'b1;
		q();
		scl <= 1'b1;
		q();
		sda_h <= 1'b0;
		q();
		scl <= 1'b0;
		q();
	endtask

	task automatic stop();
		sda_h <= 1'b0;
		q();
		scl <= 1'b1;
		q();
		sda_h <= 1'b1;
		q();
	endtask

	task automatic wr(input logic [7:0] c, input int n, input logic [15:0] d);
		logic [7:0] r;
		start();
		xb({DEV_ADDR, 1'b0}, 1'b1, r);
		xb(c, 1'b1, r);
		for (int i = 0; i < n; i++) begin
			xb(d[8 * i +: 8], 1'b1, r);
		end
		stop();
	endtask

	task automatic rd(input logic [7:0] c, input int n);
		logic [7:0]  r;
		logic [15:0] v;
		v = 16'h0000;
		start();
		xb({DEV_ADDR, 1'b0}, 1'b1, r);
		xb(c, 1'b1, r);
		start();
		xb({DEV_ADDR, 1'b1}, 1'b1, r);
		for (int i = 0; i < n; i++) begin
			xb(8'hff, i == n - 1, r);
			v[8 * i +: 8] = r;
		end
		stop();
		rd_data <= v;
		rd_done <= 1'b1;
		@(posedge core_clk);
		rd_done <= 1'b0;
	endtask
endmodule

// file: testbench/test_pwsc_top.sv
// Self-checking bench of the command bank
`timescale 1ns/1ps
module test_pwsc_top;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        sync_clk = 1'b0;
	logic        aux_supply_ok = 1'b0;
	logic        uv_alert_mask = 1'b0;
	logic        vin_valid = 1'b0;
	logic        probe = 1'b0;
	logic [15:0] vin_code = 16'h0000;
	logic [7:0]  gcfg = 8'h00;
	logic [7:0]  res_ph = 8'h05;
	logic [7:0]  res_sy = 8'h02;
	logic        res_on = 1'b1;
	logic        sync_out;
	logic [2:0]  sel = 3'd0;
	logic [31:0] seed = 32'h81a0;
	logic [7:0]  code;
	logic [15:0] obs;
	logic [15:0] rd_data;
	logic [8:0]  phase_offset_deg;
	logic        scl, sda, sda_oe, alert_out, alert_oe, sync_oe, rd_done;
	logic        ext_sync_used, ext_sync_strap, conversion_on, uv_warning;
	logic [15:0] expq[$];
	int          failures = 0;
	int          compares = 0;

	always #50 core_clk = ~core_clk;
	always #40 sync_clk = ~sync_clk;

	pwsc_top i_pwsc_top (.core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
		.alert_out(alert_out), .alert_oe(alert_oe), .sync_clk(sync_clk), .sync_out(sync_out), .sync_oe(sync_oe),
		.vin_code(vin_code), .vin_valid(vin_valid), .aux_supply_ok(aux_supply_ok), .global_configuration(gcfg),
		.nvm_phase(8'h00), .nvm_sync(8'h00), .nvm_start(16'h3d9a), .nvm_stop(16'h3d66), .nvm_uv_warn(16'hbc00),
		.res_present(res_on), .res_phase(res_ph), .res_sync(res_sy), .uv_alert_mask(uv_alert_mask),
		.phase_offset_deg(phase_offset_deg), .ext_sync_used(ext_sync_used), .ext_sync_strap(ext_sync_strap),
		.conversion_on(conversion_on), .uv_warning(uv_warning));

	pwsc_host_model i_pwsc_host_model (.core_clk(core_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda),
		.rd_done(rd_done), .rd_data(rd_data));

	always_comb begin
		case (sel)
			3'd0: obs = {7'h00, phase_offset_deg};
			3'd1: obs = {15'h0000, ext_sync_used};
			3'd2: obs = {15'h0000, ext_sync_strap};
			3'd3: obs = {15'h0000, conversion_on};
			3'd4: obs = {15'h0000, uv_warning};
			3'd5: obs = {15'h0000, alert_oe};
			default: obs = {15'h0000, sync_oe};
		endcase
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		if (failures == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic note(input logic [2:0] s, input logic [15:0] e);
		expq.push_back(e);
		sel <= s;
		probe <= 1'b1;
		@(posedge core_clk);
		probe <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic rdx(input logic [7:0] c, input int n, input logic [15:0] e);
		expq.push_back(e);
		i_pwsc_host_model.rd(c, n);
	endtask

	task automatic wrx(input logic [7:0] c, input int n, input logic [15:0] d);
		i_pwsc_host_model.wr(c, n, d);
		repeat (4) @(posedge core_clk);
	endtask

	task automatic smp(input logic [15:0] v);
		vin_code <= v;
		vin_valid <= 1'b1;
		@(posedge core_clk);
		vin_valid <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask

	// Result watcher
	always @(posedge core_clk) begin
		if (probe || rd_done) begin
			chk(probe ? obs : rd_data, expq.pop_front());
		end
	end

	initial begin
		#9000000;
		failures++;
		test_done();
	end

	initial begin
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		repeat (35) @(posedge core_clk);
		note(3'd1, 16'h0001);
		repeat (20) @(posedge core_clk);
		note(3'd2, 16'h0001);
		note(3'd1, 16'h0000);
		note(3'd0, 16'd75);
		rdx(8'hf6, 1, 16'h0002);
		rdx(8'h35, 2, 16'h3d9a);
		rdx(8'h36, 2, 16'h3d66);
		rdx(8'h58, 2, 16'hbc00);
		wrx(8'hf6, 1, 16'h00fc);
		rdx(8'hf6, 1, 16'h0000);
		note(3'd1, 16'h0001);
		wrx(8'hf6, 1, 16'h0001);
		note(3'd1, 16'h0000);
		note(3'd6, 16'h0000);
		wrx(8'h58, 2, 16'h4000);
		smp(16'h3e00);
		note(3'd4, 16'h0000);
		note(3'd3, 16'h0000);
		smp(16'h4200);
		note(3'd3, 16'h0001);
		note(3'd6, 16'h0001);
		smp(16'h3e00);
		note(3'd4, 16'h0001);
		note(3'd5, 16'h0001);
		rdx(8'h78, 1, 16'h0001);
		rdx(8'h79, 2, 16'h2001);
		rdx(8'h7c, 1, 16'h0020);
		smp(16'h3d66);
		note(3'd3, 16'h0000);
		uv_alert_mask <= 1'b1;
		wrx(8'h03, 0, 16'h0000);
		note(3'd4, 16'h0000);
		aux_supply_ok <= 1'b1;
		repeat (6) @(posedge core_clk);
		smp(16'h3e00);
		note(3'd3, 16'h0001);
		note(3'd4, 16'h0001);
		note(3'd5, 16'h0000);
		wrx(8'h35, 2, 16'h4c01);
		rdx(8'h35, 2, 16'h3d9a);
		wrx(8'h35, 2, 16'h4c00);
		rdx(8'h35, 2, 16'h4c00);
		for (int k = 0; k < 4; k++) begin
			wrx(8'hf6, 1, 16'(k));
			note(3'd1, {15'h0000, k == 0});
		end
		for (int k = 0; k < 9; k++) begin
			seed = xs(seed);
			code = (k == 8) ? 8'h17 : 8'(seed % 24);
			wrx(8'hf5, 1, {8'h00, code});
			note(3'd0, {7'h00, code * 9'd15});
		end
		// Second power-up with resistor override disabled
		seed = xs(seed);
		gcfg   <= 8'h40;
		res_ph <= seed[7:0];
		res_sy <= seed[15:8];
		rst    <= 1'b1;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		note(3'd3, 16'h0000);
		repeat (60) @(posedge core_clk);
		note(3'd0, 16'h0000);
		note(3'd2, 16'h0000);
		note(3'd1, 16'h0001);
		test_done();
	end
endmodule
